/* File: core/memory_map_decoder.sv */
// Memory map decoder: steers CPU word accesses to SRAM, peripheral registers,
// program flash or information block; supplies vectors and fetch-fault reset.
// Assumes CPU inputs are synchronous to i_sys_clk; one access per cycle.
`default_nettype none
module memory_map_decoder
    import memory_map_decoder_pkg::*;
#(
    parameter int SRAM_WORDS = 2048
)(
    // Clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_rstn,
    // CPU access
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_rd,
    input  wire logic              i_wr,
    input  wire logic              i_fetch,
    input  wire logic [DATA_W-1:0] i_periph_rdata,
    // Flash configuration, programming path and illegal-address flag clear
    input  wire logic              i_info_sel,
    input  wire logic              i_bank_wr_en,
    input  wire logic              i_prog_path,
    input  wire logic              i_fault_clear,
    // Vector requests
    input  wire logic [1:0]        i_vec_req,
    input  wire logic [2:0]        i_irq_level,
    // Target selects
    output logic                   o_sram_sel,
    output logic                   o_periph_sel,
    output logic                   o_flash_sel,
    output logic                   o_info_sel,
    output logic                   o_option_sel,
    output logic                   o_target_wr,
    output logic [DATA_W-1:0]      o_periph_rdata,
    output logic [3:0]             o_flash_bank,
    output logic [6:0]             o_flash_frame,
    output logic                   o_flash_wr_ok,
    // Vectors, stack and fault reset
    output logic [PC_W-1:0]        o_vector_addr,
    output logic [PC_W-1:0]        o_reset_pc,
    output logic [PC_W-1:0]        o_stack_pointer_init,
    output logic                   o_cpu_reset_req,
    output logic                   o_illegal_addr_flag
);
    // The map is fixed, so only the documented SRAM depth can be served
    if (SRAM_WORDS != int'(SRAM_HI - SRAM_LO) + 1)
    begin : g_bad_sram_words
        $error("SRAM_WORDS must be 2048");
    end

    logic [DATA_W-1:0] periph_rdata_ff, nxt_periph_rdata;
    logic [PC_W-1:0]   vector_ff, nxt_vector;
    logic              cpu_reset_ff, nxt_cpu_reset;
    logic              iar_flag_ff, nxt_iar_flag;

    logic hit_sram, hit_peri, hit_peri_ill, hit_flash, hit_rsvd, hit_high;
    logic hit_info, bank_writable, illegal;

    always_comb
    begin
        hit_sram     = in_range(i_addr, SRAM_LO, SRAM_HI);
        hit_rsvd     = in_range(i_addr, RSVD_LO, RSVD_HI);
        hit_high     = (i_addr >= HIGH_RSVD_LO);
        hit_peri     = in_range(i_addr, PERI_LO, PERI_HI);
        hit_peri_ill = in_range(i_addr, PERI_ILL_LO, PERI_ILL_HI);
        hit_flash    = in_range(i_addr, FLASH_LO, FLASH_HI);
        // Info block shadows the normal block when selected
        hit_info     = i_info_sel && in_range(i_addr, INFO_LO, INFO_HI);
        bank_writable = (i_addr[14:BANK_LSB] == WR_BANK) && i_bank_wr_en;
        illegal      = hit_rsvd || hit_peri_ill || hit_high;
    end

    // Selects are combinational so the target sees them in the access cycle
    always_comb
    begin
        o_sram_sel    = hit_sram;
        o_periph_sel  = hit_peri && peri_present(i_addr);
        o_flash_sel   = hit_flash && !i_info_sel;
        o_info_sel    = hit_info;
        o_option_sel  = hit_info && (i_addr == OPTION_ADDR);
        o_flash_bank  = i_addr[14:BANK_LSB];
        o_flash_frame = i_addr[14:FRAME_LSB];
        o_flash_wr_ok = o_flash_sel && bank_writable;
        if (hit_info)
        begin
            o_target_wr = i_wr && i_prog_path;
        end
        else if (o_flash_sel)
        begin
            o_target_wr = i_wr && (bank_writable || i_prog_path);
        end
        else
        begin
            o_target_wr = i_wr && (o_sram_sel || o_periph_sel);
        end
    end

    always_comb
    begin
        // Reserved peripheral holes read back zero
        nxt_periph_rdata = (i_rd && hit_peri && peri_present(i_addr)) ?
                           i_periph_rdata : '0;
        unique case (vec_req_type'(i_vec_req))
            VREQ_NONE:  nxt_vector = VEC_RESET;
            VREQ_BREAK: nxt_vector = VEC_BREAK;
            VREQ_FAST:  nxt_vector = VEC_FAST;
            VREQ_IRQ:   nxt_vector = VEC_IRQ_BASE + {13'h0000, i_irq_level};
        endcase
        nxt_cpu_reset = i_fetch && illegal;
        // Set wins over clear
        nxt_iar_flag  = (i_fetch && illegal) ||
                        (iar_flag_ff && !i_fault_clear);
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            periph_rdata_ff <= '0;
            vector_ff       <= VEC_RESET;
            cpu_reset_ff    <= 1'b0;
            iar_flag_ff     <= 1'b0;
        end
        else
        begin
            periph_rdata_ff <= nxt_periph_rdata;
            vector_ff       <= nxt_vector;
            cpu_reset_ff    <= nxt_cpu_reset;
            iar_flag_ff     <= nxt_iar_flag;
        end
    end

    assign o_periph_rdata       = periph_rdata_ff;
    assign o_vector_addr        = vector_ff;
    assign o_reset_pc           = VEC_RESET;
    assign o_stack_pointer_init = SP_INIT;
    assign o_cpu_reset_req      = cpu_reset_ff;
    assign o_illegal_addr_flag  = iar_flag_ff;

    property p_sram_route;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_addr <= SRAM_HI) |-> o_sram_sel && !o_flash_sel && !o_periph_sel;
    endproperty
    a_sram_route: assert property (p_sram_route) else $error("sram not selected");

    property p_reserved_none;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (hit_rsvd || hit_high) |-> !(o_sram_sel || o_periph_sel || o_flash_sel || o_info_sel);
    endproperty
    a_reserved_none: assert property (p_reserved_none) else $error("target in hole");

    property p_peri_illegal;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_addr >= PERI_ILL_LO && i_addr <= PERI_ILL_HI) |-> !o_periph_sel;
    endproperty
    a_peri_illegal: assert property (p_peri_illegal) else $error("illegal peri sel");

    property p_exclusive;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        !(o_info_sel && o_flash_sel);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("info and flash both");

    property p_ro_bank;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (o_flash_sel && o_flash_bank != WR_BANK && !i_prog_path) |-> !o_target_wr;
    endproperty
    a_ro_bank: assert property (p_ro_bank) else $error("write to ro bank");

    property p_info_write;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (o_info_sel && o_target_wr) |-> i_prog_path;
    endproperty
    a_info_write: assert property (p_info_write) else $error("info write w/o path");

    property p_fetch_reset;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_fetch && hit_rsvd) |=> o_cpu_reset_req && o_illegal_addr_flag;
    endproperty
    a_fetch_reset: assert property (p_fetch_reset) else $error("no illegal reset");

    property p_irq_vec;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_vec_req == VREQ_IRQ) |=> o_vector_addr == VEC_IRQ_BASE + $past(i_irq_level);
    endproperty
    a_irq_vec: assert property (p_irq_vec) else $error("bad irq vector");

    property p_hole_zero;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_rd && hit_peri && !peri_present(i_addr)) |=> o_periph_rdata == 16'h0000;
    endproperty
    a_hole_zero: assert property (p_hole_zero) else $error("hole read nonzero");

    property p_periph_route;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_addr >= PERI_LO && i_addr <= PERI_HI && peri_present(i_addr)) |->
            o_periph_sel && !o_sram_sel && !o_flash_sel;
    endproperty
    a_periph_route: assert property (p_periph_route) else $error("periph missed");

    property p_peri_data;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_rd && o_periph_sel) |=> o_periph_rdata == $past(i_periph_rdata);
    endproperty
    a_peri_data: assert property (p_peri_data) else $error("bad periph data");

    property p_flash_route;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_addr >= FLASH_LO && i_addr <= FLASH_HI && !i_info_sel) |->
            o_flash_sel && !o_info_sel;
    endproperty
    a_flash_route: assert property (p_flash_route) else $error("flash missed");

    property p_bank_index;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        o_flash_sel |-> o_flash_bank == 4'((i_addr - FLASH_LO) >> BANK_LSB);
    endproperty
    a_bank_index: assert property (p_bank_index) else $error("bad bank");

    property p_frame_index;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        o_flash_sel |-> o_flash_frame == 7'((i_addr - FLASH_LO) >> FRAME_LSB);
    endproperty
    a_frame_index: assert property (p_frame_index) else $error("bad frame");

    property p_info_route;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_info_sel && i_addr >= INFO_LO && i_addr <= INFO_HI) |->
            o_info_sel && !o_flash_sel;
    endproperty
    a_info_route: assert property (p_info_route) else $error("info missed");

    property p_option;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        o_option_sel |-> o_info_sel && (i_addr == INFO_LO);
    endproperty
    a_option: assert property (p_option) else $error("bad option sel");

    property p_sram_write;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (o_sram_sel && i_wr) |-> o_target_wr;
    endproperty
    a_sram_write: assert property (p_sram_write) else $error("sram write lost");

    property p_wr_bank_ok;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_wr && o_flash_sel && o_flash_bank == WR_BANK && i_bank_wr_en) |->
            o_flash_wr_ok && o_target_wr;
    endproperty
    a_wr_bank_ok: assert property (p_wr_bank_ok) else $error("bank write lost");

    property p_ro_drop;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (o_flash_sel && !i_bank_wr_en && !i_prog_path) |-> !o_target_wr && !o_flash_wr_ok;
    endproperty
    a_ro_drop: assert property (p_ro_drop) else $error("ro write passed");

    property p_hole_nowrite;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (hit_peri && !peri_present(i_addr)) |-> !o_periph_sel && !o_target_wr;
    endproperty
    a_hole_nowrite: assert property (p_hole_nowrite) else $error("hole written");

    property p_rdata_idle;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        !i_rd |=> o_periph_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("idle rdata nonzero");

    property p_vec_reset;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_vec_req == VREQ_NONE) |=> o_vector_addr == VEC_RESET;
    endproperty
    a_vec_reset: assert property (p_vec_reset) else $error("bad reset vector");

    property p_vec_break;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_vec_req == VREQ_BREAK) |=> o_vector_addr == VEC_BREAK;
    endproperty
    a_vec_break: assert property (p_vec_break) else $error("bad break vector");

    property p_vec_fast;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_vec_req == VREQ_FAST) |=> o_vector_addr == VEC_FAST;
    endproperty
    a_vec_fast: assert property (p_vec_fast) else $error("bad fast vector");

    property p_sp_top;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        o_stack_pointer_init == SRAM_HI[15:0];
    endproperty
    a_sp_top: assert property (p_sp_top) else $error("bad stack pointer");

    property p_flag_hold;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (o_illegal_addr_flag && !i_fault_clear) |=> o_illegal_addr_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

    property p_reset_pulse;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        !(i_fetch && illegal) |=> !o_cpu_reset_req;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset req stuck");

    property p_peri_ill_fetch;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_fetch && hit_peri_ill) |=> o_cpu_reset_req && o_illegal_addr_flag;
    endproperty
    a_peri_ill_fetch: assert property (p_peri_ill_fetch) else $error("no peri fault");

    property p_high_fetch;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_fetch && hit_high) |=> o_cpu_reset_req && o_illegal_addr_flag;
    endproperty
    a_high_fetch: assert property (p_high_fetch) else $error("no high fault");

    c_sram:   cover property (@(posedge i_sys_clk) disable iff (!i_rstn) o_sram_sel && i_wr);
    c_bank_w: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) o_flash_wr_ok && i_wr);
    c_info:   cover property (@(posedge i_sys_clk) disable iff (!i_rstn) o_option_sel);
    c_iar:    cover property (@(posedge i_sys_clk) disable iff (!i_rstn) o_cpu_reset_req);
    c_irq:    cover property (@(posedge i_sys_clk) disable iff (!i_rstn) i_vec_req == VREQ_IRQ);
endmodule
`default_nettype wire

/* File: core/memory_map_decoder_pkg.sv */
// Package for the memory map decoder: address map, vectors, widths.
// Assumes a single system clock domain and a 22-bit word address bus.
`default_nettype none
package memory_map_decoder_pkg;
    localparam int ADDR_W = 22;
    localparam int PC_W   = 16;
    localparam int DATA_W = 16;

    localparam logic [21:0] SRAM_LO      = 22'h000000;
    localparam logic [21:0] SRAM_HI      = 22'h0007FF;
    localparam logic [21:0] RSVD_LO      = 22'h000800;
    localparam logic [21:0] RSVD_HI      = 22'h006FFF;
    localparam logic [21:0] PERI_LO      = 22'h007000;
    localparam logic [21:0] PERI_HI      = 22'h0075FF;
    localparam logic [21:0] PERI_ILL_LO  = 22'h007600;
    localparam logic [21:0] PERI_ILL_HI  = 22'h007FFF;
    localparam logic [21:0] FLASH_LO     = 22'h008000;
    localparam logic [21:0] FLASH_HI     = 22'h00FFFF;
    localparam logic [21:0] HIGH_RSVD_LO = 22'h010000;
    localparam logic [21:0] INFO_LO      = 22'h008000;
    localparam logic [21:0] INFO_HI      = 22'h00803F;
    localparam logic [21:0] OPTION_ADDR  = 22'h008000;

    // Flash banks and frames
    localparam int          BANK_COUNT   = 16;
    localparam int          BANK_LSB     = 11;
    localparam int          FRAME_LSB    = 8;
    localparam logic [3:0]  WR_BANK      = 4'hE;
    localparam int          FRAME_COUNT  = 128;

    // Stack pointer starts at top of SRAM
    localparam logic [15:0] SP_INIT      = 16'h07FF;

    // Vector table
    localparam logic [15:0] VEC_BREAK    = 16'hFFF5;
    localparam logic [15:0] VEC_FAST     = 16'hFFF6;
    localparam logic [15:0] VEC_RESET    = 16'hFFF7;
    localparam logic [15:0] VEC_IRQ_BASE = 16'hFFF8;

    // Vector request kinds
    typedef enum logic [1:0] {
        VREQ_NONE  = 2'b00,
        VREQ_BREAK = 2'b01,
        VREQ_FAST  = 2'b10,
        VREQ_IRQ   = 2'b11
    } vec_req_type;

    // Implemented peripheral subranges; anything else in the window is reserved
    function automatic logic peri_present(input logic [21:0] a);
        logic [15:0] w;
        w = a[15:0];
        peri_present = (w >= 16'h7000 && w <= 16'h704F) ||
                       (w >= 16'h7060 && w <= 16'h70DF) ||
                       (w >= 16'h7100 && w <= 16'h711F) ||
                       (w >= 16'h7140 && w <= 16'h715F) ||
                       (w >= 16'h7400 && w <= 16'h747F) ||
                       (w >= 16'h7500 && w <= 16'h751F);
    endfunction

    function automatic logic in_range(input logic [21:0] a,
                                      input logic [21:0] lo,
                                      input logic [21:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction
endpackage
`default_nettype wire

/* File: tb/cpu_model.sv */
// CPU model: issues one word access per clock on the decoder's request side.
// Assumes requests launch 1 ns after the rising edge of the system clock.
`default_nettype none
module cpu_model
    import memory_map_decoder_pkg::*;
(
    // Clock
    input  wire logic              i_sys_clk,
    // Access request
    output var  logic [ADDR_W-1:0] o_addr,
    output var  logic              o_rd,
    output var  logic              o_wr,
    output var  logic              o_fetch
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        o_addr  = '0;
        o_rd    = 1'b0;
        o_wr    = 1'b0;
        o_fetch = 1'b0;
    end

    // Whole 22-bit word address each access, held until the next access
    task automatic access(input logic [ADDR_W-1:0] a, input logic r, input logic w,
                          input logic f);
        @(posedge i_sys_clk);
        #1;
        o_addr  = a;
        o_rd    = r;
        o_wr    = w;
        o_fetch = f;
    endtask
endmodule
`default_nettype wire

/* File: tb/memory_map_decoder_test.sv */
// Bench for the memory map decoder: decode map, write gating, vectors, fetch faults.
// Assumes the CPU model drives address and strobes; the bench drives the rest.
`default_nettype none
module memory_map_decoder_test;
    timeunit 1ns;
    timeprecision 100ps;
    import memory_map_decoder_pkg::*;

    logic              sys_clk, rstn, info_sel, bank_wr_en, prog_path, fault_clear;
    logic [ADDR_W-1:0] addr;
    logic              rd, wr, fetch;
    logic [DATA_W-1:0] periph_in;
    logic [1:0]        vec_req;
    logic [2:0]        irq_level;
    logic              sram_s, periph_s, flash_s, info_s, option_s, target_wr, wr_ok;
    logic              reset_req, ill_flag;
    logic [DATA_W-1:0] periph_out;
    logic [3:0]        bank;
    logic [6:0]        frame;
    logic [PC_W-1:0]   vec_addr, reset_pc, sp_init;
    int                bad_count = 0;
    int                checked   = 0;

    cpu_model u_cpu_model (.i_sys_clk(sys_clk), .o_addr(addr), .o_rd(rd), .o_wr(wr),
        .o_fetch(fetch));
    memory_map_decoder u_memory_map_decoder (.i_sys_clk(sys_clk), .i_rstn(rstn),
        .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_fetch(fetch), .i_periph_rdata(periph_in),
        .i_info_sel(info_sel), .i_bank_wr_en(bank_wr_en), .i_prog_path(prog_path),
        .i_fault_clear(fault_clear), .i_vec_req(vec_req), .i_irq_level(irq_level),
        .o_sram_sel(sram_s), .o_periph_sel(periph_s), .o_flash_sel(flash_s),
        .o_info_sel(info_s), .o_option_sel(option_s), .o_target_wr(target_wr),
        .o_periph_rdata(periph_out), .o_flash_bank(bank), .o_flash_frame(frame),
        .o_flash_wr_ok(wr_ok), .o_vector_addr(vec_addr), .o_reset_pc(reset_pc),
        .o_stack_pointer_init(sp_init), .o_cpu_reset_req(reset_req),
        .o_illegal_addr_flag(ill_flag));

    // Decode table: address, info block chosen, {sram,periph,flash,info,option}
    localparam logic [21:0] DA [13] = '{22'h000000, 22'h0007FF, 22'h000800, 22'h006FFF,
        22'h007000, 22'h00751F, 22'h007600, 22'h008000, 22'h00FFFF, 22'h010000,
        22'h008000, 22'h00803F, 22'h008040};
    localparam logic        DI [13] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
        1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    localparam logic [4:0]  DE [13] = '{5'h10, 5'h10, 5'h00, 5'h00, 5'h08, 5'h08, 5'h00,
        5'h04, 5'h04, 5'h00, 5'h03, 5'h02, 5'h00};
    // Write table: address, {info,bank_en,prog,exp target_wr,exp flash_wr_ok}
    localparam logic [21:0] WA [9] = '{22'h00F000, 22'h00F7FF, 22'h00E7FF, 22'h008001,
        22'h008001, 22'h000100, 22'h007050, 22'h000800, 22'h00E7FF};
    localparam logic [4:0]  WF [9] = '{5'h0B, 5'h00, 5'h08, 5'h10, 5'h16, 5'h02, 5'h00,
        5'h00, 5'h06};

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reset_test();
        check_word("reset vector", 16'hFFF7, vec_addr);
        check_word("reset pc", 16'hFFF7, reset_pc);
        check_word("stack pointer init", 16'h07FF, sp_init);
        check_word("fault idle", 16'h0000, {14'h0, reset_req, ill_flag});
    endtask

    task automatic decode_test();
        for (int k = 0; k < 13; k++)
        begin
            u_cpu_model.access(DA[k], 1'b1, 1'b0, 1'b0);
            info_sel = DI[k];
            #1;
            check_word("selects", {11'h0, DE[k]},
                {11'h0, sram_s, periph_s, flash_s, info_s, option_s});
        end
        u_cpu_model.access(22'h00F7FF, 1'b1, 1'b0, 1'b0);
        info_sel = 1'b0;
        #1;
        check_word("bank and frame", 16'h0E77, {4'h0, bank, 1'b0, frame});
    endtask

    task automatic write_test();
        for (int k = 0; k < 9; k++)
        begin
            u_cpu_model.access(WA[k], 1'b0, 1'b1, 1'b0);
            {info_sel, bank_wr_en, prog_path} = WF[k][4:2];
            #1;
            check_word("write gate", {14'h0, WF[k][1:0]}, {14'h0, target_wr, wr_ok});
        end
        @(posedge sys_clk);
        #1;
        {info_sel, bank_wr_en, prog_path} = 3'h0;
    endtask

    task automatic periph_test();
        u_cpu_model.access(22'h007006, 1'b1, 1'b0, 1'b0);
        u_cpu_model.access(22'h007050, 1'b1, 1'b0, 1'b0);
        #1;
        check_word("periph read", 16'hA5C3, periph_out);
        u_cpu_model.access(22'h000000, 1'b0, 1'b0, 1'b0);
        #1;
        check_word("hole read", 16'h0000, periph_out);
    endtask

    task automatic fault_test(input logic [21:0] a);
        u_cpu_model.access(a, 1'b1, 1'b0, 1'b1);
        u_cpu_model.access(22'h000000, 1'b0, 1'b0, 1'b0);
        #1;
        check_word("fault set", 16'h0003, {14'h0, reset_req, ill_flag});
        @(posedge sys_clk);
        #1;
        check_word("fault pulse end", 16'h0001, {14'h0, reset_req, ill_flag});
        fault_clear = 1'b1;
        @(posedge sys_clk);
        #1;
        fault_clear = 1'b0;
        check_word("fault clear", 16'h0000, {14'h0, reset_req, ill_flag});
    endtask

    // Fault and clear in one cycle: the fault must win
    task automatic fault_race_test();
        u_cpu_model.access(22'h010000, 1'b1, 1'b0, 1'b1);
        fault_clear = 1'b1;
        u_cpu_model.access(22'h000000, 1'b0, 1'b0, 1'b0);
        #1;
        check_word("set beats clear", 16'h0003, {14'h0, reset_req, ill_flag});
        @(posedge sys_clk);
        #1;
        check_word("clear after set", 16'h0000, {14'h0, reset_req, ill_flag});
        fault_clear = 1'b0;
    endtask

    // Reset in mid-run must drop the flag and restore the reset vector
    task automatic mid_reset_test();
        vec_req = 2'b01;
        u_cpu_model.access(22'h010000, 1'b1, 1'b0, 1'b1);
        u_cpu_model.access(22'h000000, 1'b0, 1'b0, 1'b0);
        #1;
        check_word("break vector", 16'hFFF5, vec_addr);
        check_word("high fetch fault", 16'h0003, {14'h0, reset_req, ill_flag});
        @(posedge sys_clk);
        #1;
        {rstn, vec_req} = 3'h0;
        @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        reset_test();
    endtask

    task automatic vector_test();
        for (int k = 0; k < 11; k++)
        begin
            vec_req   = (k == 10) ? 2'b00 : (k < 2) ? 2'(k + 1) : 2'b11;
            irq_level = 3'(k - 2);
            @(posedge sys_clk);
            #1;
            check_word("vector", (k == 10) ? 16'hFFF7 : (k < 2) ? 16'(16'hFFF5 + k)
                : 16'(16'hFFF6 + k), vec_addr);
        end
    endtask

    initial
    begin
        {rstn, info_sel, bank_wr_en, prog_path, fault_clear} = 5'h0;
        periph_in = 16'hA5C3;
        vec_req   = 2'b00;
        irq_level = 3'h0;
        repeat (8) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        reset_test();
        decode_test();
        write_test();
        periph_test();
        fault_test(22'h000800);
        fault_test(22'h007600);
        fault_race_test();
        vector_test();
        mid_reset_test();
        wrap_up();
    end

    // Whole run is about 60 cycles
    initial
    begin
        #100us;
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
